// file: shared/atfs_pkg.sv
`default_nettype none
package atfs_pkg;
    // register word index on the plain register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_DELAY = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CHAN = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_REMAIN = 3'h5;
    // control word fields
    localparam int CTRL_W = 10;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CNT_EN = 1;
    localparam int CTRL_SRC_LO = 2;
    localparam int CTRL_SRC_HI = 3;
    localparam int CTRL_CONT = 4;
    localparam int CTRL_AUTO = 5;
    localparam int CTRL_MASTER = 6;
    localparam int CTRL_IE_FRAME = 7;
    localparam int CTRL_IE_HALF = 8;
    localparam int CTRL_IE_XFER = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 10'h002;
    // trigger source codes
    localparam logic [1:0] SRC_ANALOG = 2'h0;
    localparam logic [1:0] SRC_DIGITAL = 2'h1;
    localparam logic [1:0] SRC_INTERNAL = 2'h2;
    // status word fields
    localparam int ST_BUSY = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_OVF = 2;
    localparam int ST_HALF = 3;
    localparam int ST_FULL = 4;
    localparam int ST_EMPTY = 5;
    localparam int ST_FRAME = 6;
    localparam int ST_XFER = 7;
    localparam int ST_W = 8;
    // widths and reset values
    localparam int CNT_W = 24;
    localparam int SAMPLE_W = 16;
    localparam int CHAN_W = 4;
    localparam int CHAN_SEL_LO = 0;
    localparam logic [CNT_W-1:0] COUNT_RST = 24'h000000;
    localparam logic [CNT_W-1:0] DELAY_RST = 24'h000000;
    localparam logic [CHAN_W-1:0] CHAN_RST = 4'h0;
endpackage : atfs_pkg
`default_nettype wire

// file: src/atfs_itrig.sv
`timescale 1ns/1ps
`default_nettype none
module atfs_itrig (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic enable,
    input wire logic start,
    input wire logic continuous,
    input wire logic [atfs_pkg::CNT_W-1:0] period,
    input wire logic sample_tick,
    output logic trig
);
    import atfs_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic pend_reg;
    logic pend_next;
    logic trig_next;
    wire fire = enable && sample_tick && (cnt_reg == '0) &&
                (pend_reg || continuous);

    // pulses only in the cycle after a sample tick, so triggers line up with the a/d clock
    always_comb begin
        cnt_next = cnt_reg;
        pend_next = pend_reg;
        trig_next = 1'b0;
        if (!enable) begin
            cnt_next = '0;
            pend_next = 1'b0;
        end else if (start) begin
            cnt_next = '0;
            pend_next = 1'b1;
        end else if (fire) begin
            cnt_next = period;
            pend_next = 1'b0;
            trig_next = 1'b1;
        end else if (sample_tick && cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            pend_reg <= 1'b0;
            trig <= 1'b0;
        end else if (ce) begin
            cnt_reg <= cnt_next;
            pend_reg <= pend_next;
            trig <= trig_next;
        end
    end
endmodule : atfs_itrig
`default_nettype wire

// file: src/atfs_pack.sv
`timescale 1ns/1ps
`default_nettype none
module atfs_pack (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic clear,
    input wire logic in_valid,
    input wire logic [atfs_pkg::SAMPLE_W-1:0] in_data,
    input wire logic fifo_full,
    output logic wr_valid,
    output logic [2*atfs_pkg::SAMPLE_W-1:0] wr_data,
    output logic overflow
);
    import atfs_pkg::*;

    logic half_reg;
    logic [SAMPLE_W-1:0] low_reg;
    wire pair_done = in_valid && half_reg;
    wire accept = pair_done && !fifo_full;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            half_reg <= 1'b0;
            low_reg <= '0;
            wr_valid <= 1'b0;
            wr_data <= '0;
            overflow <= 1'b0;
        end else if (ce) begin
            wr_valid <= accept;
            overflow <= pair_done && fifo_full;
            if (clear) begin
                half_reg <= 1'b0;
            end else if (in_valid) begin
                half_reg <= !half_reg;
                if (!half_reg) begin
                    low_reg <= in_data;
                end
            end
            if (accept) begin
                wr_data <= {in_data, low_reg};
            end
        end
    end
endmodule : atfs_pack
`default_nettype wire

// file: src/atfs_sequencer.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module atfs_sequencer #(
    parameter int FIFO_WORDS = 4096,
    parameter int FIFO_CNT_W = 13
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [atfs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [atfs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [atfs_pkg::DATA_W-1:0] reg_rdata,
    input wire logic sample_tick,
    input wire logic [atfs_pkg::SAMPLE_W-1:0] sample_data,
    input wire logic ana_trip_pin,
    input wire logic dig_trig_pin,
    input wire logic [atfs_pkg::CHAN_W-1:0] module_top_chan,
    input wire logic [FIFO_CNT_W-1:0] fifo_count,
    input wire logic xfer_done,
    output logic fifo_wr_valid,
    output logic [2*atfs_pkg::SAMPLE_W-1:0] fifo_wr_data,
    output logic [atfs_pkg::CHAN_W-1:0] chan_addr,
    output logic trig_out,
    output logic acquiring,
    output logic frame_done_interrupt,
    output logic pci_irq
);
    import atfs_pkg::*;

    generate
        if (FIFO_WORDS < 2 || FIFO_WORDS >= (1 << FIFO_CNT_W)) begin : g_chk
            $error("atfs_sequencer: FIFO_WORDS does not fit FIFO_CNT_W");
        end
    endgenerate

    typedef enum logic [1:0] {IDLE, ARMED, ACQ} atfs_state_t;

    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    localparam int SYN_W = CHAN_W + 2;
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    logic [1:0] trig_prev_reg;
    wire [SYN_W-1:0] pins = {module_top_chan, dig_trig_pin, ana_trip_pin};
    wire [CHAN_W-1:0] top_chan = syn2_reg[SYN_W-1:2];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            syn1_reg <= '0;
            syn2_reg <= '0;
            trig_prev_reg <= '0;
        end else if (ce) begin
            syn1_reg <= pins;
            syn2_reg <= syn1_reg;
            trig_prev_reg <= syn2_reg[1:0];
        end
    end

    wire [1:0] pin_edge = syn2_reg[1:0] & ~trig_prev_reg;

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [CTRL_W-1:0] ctrl_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] delay_reg;
    logic [CHAN_W-1:0] chan_sel_reg;
    logic ovf_reg;
    logic frame_flag_reg;
    logic half_flag_reg;
    logic xfer_flag_reg;
    logic half_prev_reg;
    logic run_prev_reg;

    wire wr_ctrl = reg_we && reg_addr == OFS_CTRL;
    wire wr_count = reg_we && reg_addr == OFS_COUNT;
    wire wr_delay = reg_we && reg_addr == OFS_DELAY;
    wire wr_chan = reg_we && reg_addr == OFS_CHAN;
    wire wr_status = reg_we && reg_addr == OFS_STATUS;

    wire run = ctrl_reg[CTRL_RUN];
    wire cnt_en = ctrl_reg[CTRL_CNT_EN];
    wire [1:0] src = ctrl_reg[CTRL_SRC_HI:CTRL_SRC_LO];
    wire auto_inc = ctrl_reg[CTRL_AUTO];
    wire arm_evt = run && !run_prev_reg;

    // fifo flags from occupancy alone
    wire fifo_half = fifo_count >= FIFO_CNT_W'(FIFO_WORDS / 2);
    wire fifo_full = fifo_count >= FIFO_CNT_W'(FIFO_WORDS);
    wire fifo_empty = fifo_count == '0;

    //////////////////////////////////////////////////////////////////////////
    // trigger selection
    logic int_trig;
    atfs_itrig u_itrig (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .enable(run && src == SRC_INTERNAL),
        .start(arm_evt),
        .continuous(ctrl_reg[CTRL_CONT]),
        .period(delay_reg),
        .sample_tick(sample_tick),
        .trig(int_trig)
    );

    // one source, one common start pulse
    wire trig_sel = (src == SRC_ANALOG) ? pin_edge[0] :
                    (src == SRC_DIGITAL) ? pin_edge[1] :
                    (src == SRC_INTERNAL) ? int_trig : 1'b0;

    //////////////////////////////////////////////////////////////////////////
    // frame sequencer
    atfs_state_t state_reg;
    atfs_state_t state_next;
    logic [CNT_W-1:0] remain_reg;
    logic [CNT_W-1:0] remain_next;
    logic [CHAN_W-1:0] chan_next;

    wire take = state_reg == ARMED && trig_sel;
    wire sample_in = state_reg == ACQ && sample_tick;
    wire last = sample_in && cnt_en && remain_reg == '0;
    wire single_int = src == SRC_INTERNAL && !ctrl_reg[CTRL_CONT];

    always_comb begin
        state_next = state_reg;
        remain_next = remain_reg;
        if (!run) begin
            state_next = IDLE;
        end else begin
            unique case (state_reg)
                IDLE: begin
                    if (arm_evt) begin
                        state_next = ARMED;
                        remain_next = count_reg;
                    end
                end
                ARMED: begin
                    if (trig_sel) begin
                        state_next = ACQ;
                        remain_next = count_reg;
                    end
                end
                ACQ: begin
                    if (last) begin
                        // halt after one frame in single internal mode
                        state_next = single_int ? IDLE : ARMED;
                        remain_next = count_reg;
                    end else if (sample_in && cnt_en) begin
                        remain_next = remain_reg - 1'b1;
                    end
                    // counter off: runs until run is cleared
                end
            endcase
        end
    end

    // channel address moves with each sample taken in ACQ, whether or not it reaches the fifo
    wire [CHAN_W-1:0] chan_inc = (chan_addr >= top_chan) ? '0 :
                                 chan_addr + 1'b1;
    always_comb begin
        chan_next = chan_addr;
        if (!auto_inc) begin
            chan_next = chan_sel_reg;
        end else if (arm_evt) begin
            chan_next = '0;
        end else if (sample_in) begin
            chan_next = chan_inc;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // sample packing into fifo words
    logic pack_ovf;
    atfs_pack u_pack (
        .core_clk(core_clk),
        .reset(reset),
        .ce(ce),
        .clear(arm_evt),
        .in_valid(sample_in),
        .in_data(sample_data),
        .fifo_full(fifo_full),
        .wr_valid(fifo_wr_valid),
        .wr_data(fifo_wr_data),
        .overflow(pack_ovf)
    );

    //////////////////////////////////////////////////////////////////////////
    // state and register updates
    wire half_rise = fifo_half && !half_prev_reg;
    wire [ST_W-1:0] clr = wr_status ? reg_wdata[ST_W-1:0] : '0;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_reg <= IDLE;
            remain_reg <= COUNT_RST;
            chan_addr <= CHAN_RST;
            run_prev_reg <= 1'b0;
            half_prev_reg <= 1'b0;
            trig_out <= 1'b0;
            acquiring <= 1'b0;
            frame_done_interrupt <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            remain_reg <= remain_next;
            chan_addr <= chan_next;
            run_prev_reg <= run;
            half_prev_reg <= fifo_half;
            trig_out <= ctrl_reg[CTRL_MASTER] && int_trig;
            acquiring <= state_next == ACQ;
            frame_done_interrupt <= last && ctrl_reg[CTRL_IE_FRAME];
        end
    end

    // sticky flags: a set in the clear cycle wins
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= CTRL_RST;
            count_reg <= COUNT_RST;
            delay_reg <= DELAY_RST;
            chan_sel_reg <= CHAN_RST;
            ovf_reg <= 1'b0;
            frame_flag_reg <= 1'b0;
            half_flag_reg <= 1'b0;
            xfer_flag_reg <= 1'b0;
        end else if (ce) begin
            if (wr_ctrl) ctrl_reg <= reg_wdata[CTRL_W-1:0];
            if (wr_count) count_reg <= reg_wdata[CNT_W-1:0];
            if (wr_delay) delay_reg <= reg_wdata[CNT_W-1:0];
            if (wr_chan) chan_sel_reg <= reg_wdata[CHAN_W-1:0];
            ovf_reg <= pack_ovf || (ovf_reg && !clr[ST_OVF]);
            frame_flag_reg <= last || (frame_flag_reg && !clr[ST_FRAME]);
            half_flag_reg <= half_rise || (half_flag_reg && !clr[ST_HALF]);
            xfer_flag_reg <= xfer_done || (xfer_flag_reg && !clr[ST_XFER]);
        end
    end

    wire irq_next = (frame_flag_reg && ctrl_reg[CTRL_IE_FRAME]) ||
                    (half_flag_reg && ctrl_reg[CTRL_IE_HALF]) ||
                    (xfer_flag_reg && ctrl_reg[CTRL_IE_XFER]);

    //////////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    logic [DATA_W-1:0] rd_mux;
    wire [ST_W-1:0] status = {xfer_flag_reg, frame_flag_reg, fifo_empty,
                              fifo_full, half_flag_reg, ovf_reg,
                              state_reg == ARMED, state_reg == ACQ};
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            OFS_CTRL: rd_mux = DATA_W'(ctrl_reg);
            OFS_COUNT: rd_mux = DATA_W'(count_reg);
            OFS_DELAY: rd_mux = DATA_W'(delay_reg);
            OFS_CHAN: rd_mux = DATA_W'(chan_sel_reg);
            OFS_STATUS: rd_mux = DATA_W'(status);
            OFS_REMAIN: rd_mux = DATA_W'(remain_reg);
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
            pci_irq <= 1'b0;
        end else if (ce) begin
            reg_rdata <= reg_re ? rd_mux : '0;
            pci_irq <= irq_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_SRC_START: assert property (
        ce && run && state_reg == ARMED && src == SRC_DIGITAL && pin_edge[1]
        |=> state_reg == ACQ)
        else $error("digital edge did not start a frame");
    AST_SINGLE_HALT: assert property (
        ce && run && last && single_int |=> state_reg == IDLE)
        else $error("single mode did not halt");
    AST_TRIG_ON_TICK: assert property (
        ce && $rose(int_trig) |-> $past(sample_tick))
        else $error("internal trigger not aligned to sample tick");
    AST_LAST_COUNT: assert property (
        ce && run && take |=> remain_reg == $past(count_reg))
        else $error("frame length not loaded");
    AST_REARM: assert property (
        ce && run && last && !single_int |=> state_reg == ARMED)
        else $error("counted frame did not rearm");
    AST_RELOAD: assert property (
        ce && run && last |=> remain_reg == $past(count_reg))
        else $error("counter not reloaded");
    AST_NONSTOP: assert property (
        ce && run && !cnt_en && state_reg == ACQ |=> state_reg == ACQ)
        else $error("non-stop frame ended");
    AST_HALF_FLAG: assert property (
        ce && fifo_half && !half_prev_reg |=> half_flag_reg)
        else $error("half full event lost");
    AST_CHAN_FIXED: assert property (
        ce && !auto_inc ##1 ce |-> chan_addr == $past(chan_sel_reg))
        else $error("single channel address moved");
    AST_CHAN_WRAP: assert property (
        ce && auto_inc && run && !arm_evt && sample_in &&
        chan_addr >= top_chan |=> chan_addr == '0)
        else $error("channel did not wrap");
    AST_IGNORE_BUSY: assert property (
        ce && run && state_reg == ACQ && trig_sel && !sample_in
        |=> state_reg == ACQ && remain_reg == $past(remain_reg))
        else $error("trigger restarted a running frame");
    AST_OVF_HOLD: assert property (
        ce && ovf_reg && !clr[ST_OVF] |=> ovf_reg)
        else $error("overflow flag dropped");
    AST_MASTER_OUT: assert property (
        ce && ctrl_reg[CTRL_MASTER] && int_trig |=> trig_out)
        else $error("master trigger not driven out");

    COV_FRAME: cover property (ce && last ##[1:20] take);
    COV_NONSTOP: cover property (ce && !cnt_en && sample_in);
    COV_OVF: cover property (ce && pack_ovf);
    COV_WRAP: cover property (ce && auto_inc && sample_in && chan_inc == '0);
endmodule : atfs_sequencer
`default_nettype wire

// file: test/atfs_far_side.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// fifo occupancy and bus-master mover on the far side of the sequencer
module atfs_far_side (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wr_valid,
    input wire logic fill,
    input wire logic drain,
    output logic [12:0] fifo_count,
    output logic xfer_done
);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fifo_count <= 13'h0000;
            xfer_done <= 1'b0;
        end else begin
            xfer_done <= drain;
            // one drain moves the whole block, no partial transfers
            if (fill)
                fifo_count <= 13'h1000;
            else if (drain)
                fifo_count <= 13'h0000;
            else if (wr_valid && fifo_count < 13'h1000)
                fifo_count <= fifo_count + 13'h0001;
        end
    end
endmodule : atfs_far_side
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import atfs_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rd;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic sample_tick = 1'b0;
    logic [SAMPLE_W-1:0] sample_data = '0;
    logic ana = 1'b0;
    logic dig = 1'b0;
    logic fill = 1'b0;
    logic drain = 1'b0;
    logic [12:0] fifo_count;
    logic xfer_done, wr_valid, trig_out, acquiring, fdi, pci_irq;
    logic [31:0] wr_data;
    logic [CHAN_W-1:0] chan_addr;
    logic [31:0] seed = 32'h0000_0257;
    logic [15:0] q[$];
    int failures = 0;
    int n_compared = 0;
    int n_frame = 0;
    int n_trig = 0;
    int n_chan = 0;
    int k;
    bit chk = 1'b0;
    bit autoinc = 1'b0;
    bit loose = 1'b0;

    always #5 core_clk = ~core_clk;

    atfs_sequencer DUT (.core_clk(core_clk), .reset(reset), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(reg_re), .reg_rdata(reg_rdata), .sample_tick(sample_tick),
        .sample_data(sample_data), .ana_trip_pin(ana), .dig_trig_pin(dig),
        .module_top_chan(4'h2), .fifo_count(fifo_count),
        .xfer_done(xfer_done), .fifo_wr_valid(wr_valid),
        .fifo_wr_data(wr_data), .chan_addr(chan_addr), .trig_out(trig_out),
        .acquiring(acquiring), .frame_done_interrupt(fdi),
        .pci_irq(pci_irq));
    atfs_far_side far (.core_clk(core_clk), .reset(reset),
        .wr_valid(wr_valid), .fill(fill), .drain(drain),
        .fifo_count(fifo_count), .xfer_done(xfer_done));

    //////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic logic [31:0] mk(input logic [1:0] s, input bit cnt,
            input bit inc, input bit cont);
        mk = 32'h0;
        mk[CTRL_CNT_EN] = cnt;
        mk[CTRL_SRC_HI:CTRL_SRC_LO] = s;
        mk[CTRL_CONT] = cont;
        mk[CTRL_AUTO] = inc;
        mk[CTRL_MASTER] = (s == SRC_INTERNAL);
        mk[CTRL_IE_FRAME] = 1'b1;
    endfunction : mk

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %s %h/%h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask : wr

    task automatic rdx(input logic [ADDR_W-1:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdx

    // keep=0: tick not queued as expected fifo data, channel not checked
    task automatic tick(input bit keep);
        int ec;
        @(posedge core_clk);
        seed = xs(seed);
        sample_tick <= 1'b1;
        sample_data <= seed[15:0];
        if (keep)
            q.push_back(seed[15:0]);
        @(posedge core_clk);
        sample_tick <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        if (keep) begin
            n_chan++;
            ec = autoinc ? n_chan % 3 : 5;
            if (chk)
                check(32'(chan_addr), ec, "chan");
        end
    endtask : tick

    task automatic pin(input logic [1:0] s);
        @(posedge core_clk);
        ana <= (s == SRC_ANALOG);
        dig <= (s == SRC_DIGITAL);
        repeat (4) @(posedge core_clk);
        ana <= 1'b0;
        dig <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : pin

    task automatic trig(input logic [1:0] s);
        if (s == SRC_INTERNAL)
            tick(1'b0);
        else
            pin(s);
    endtask : trig

    task automatic arm(input logic [31:0] c);
        wr(OFS_CTRL, c);
        wr(OFS_CTRL, c | 32'h1);
        n_chan = 0;
        autoinc = c[CTRL_AUTO];
        repeat (3) @(posedge core_clk);
    endtask : arm

    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    //////////////////////////////////////////////////////////////////////////
    // settled values only, so sample away from the launching edge
    always @(negedge core_clk) begin
        if (trig_out)
            n_trig++;
        if (fdi)
            n_frame++;
        if (wr_valid && !loose) begin
            if (q.size() < 2) begin
                check(32'h1, 32'h0, "extra fifo write");
            end else begin
                check(wr_data, {q[1], q[0]}, "fifo word");
                q.delete(0);
                q.delete(0);
            end
        end
    end

    initial begin
        #300000;
        failures++;
        close_out();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rdx(OFS_CTRL);
        check(rd, 32'(CTRL_RST), "ctrl reset");
        wr(3'h6, 32'hffff_ffff);
        rdx(3'h6);
        check(rd, 32'h0, "unmapped");
        wr(OFS_COUNT, 32'h3);
        wr(OFS_CHAN, 32'h5);
        for (int s = 0; s < 3; s++) begin
            arm(mk(s[1:0], 1'b1, s[0], 1'b0));
            chk = 1'b1;
            trig(s[1:0]);
            tick(1'b1);
            tick(1'b1);
            pin(SRC_ANALOG);
            pin(SRC_DIGITAL);
            tick(1'b1);
            tick(1'b1);
            tick(1'b0);
            tick(1'b0);
            check(32'(acquiring), 32'h0, "frame too long");
            chk = 1'b0;
            pin(s == 0 ? SRC_DIGITAL : SRC_ANALOG);
            #1 check(32'(acquiring), 32'h0, "wrong source");
            // internal single mode must stay idle here
            trig(s[1:0]);
            repeat (4) tick(s != 2);
        end
        check(32'(n_frame), 32'h5, "frame irqs");
        check(32'(n_trig), 32'h1, "trig out");
        check(32'(pci_irq), 32'h1, "irq level");
        wr(OFS_STATUS, 32'h40);
        repeat (3) @(posedge core_clk);
        #1 check(32'(pci_irq), 32'h0, "irq clear");
        arm(mk(SRC_DIGITAL, 1'b0, 1'b1, 1'b0));
        chk = 1'b1;
        trig(SRC_DIGITAL);
        repeat (8) tick(1'b1);
        check(32'(acquiring), 32'h1, "nonstop ended");
        wr(OFS_CTRL, mk(SRC_DIGITAL, 1'b0, 1'b1, 1'b0));
        repeat (2) tick(1'b0);
        check(32'(acquiring), 32'h0, "stop ignored");
        chk = 1'b0;
        @(posedge core_clk) fill <= 1'b1;
        @(posedge core_clk) fill <= 1'b0;
        rdx(OFS_STATUS);
        check(rd & 32'h38, 32'h18, "full flags");
        arm(mk(SRC_DIGITAL, 1'b1, 1'b0, 1'b0));
        trig(SRC_DIGITAL);
        repeat (4) tick(1'b0);
        rdx(OFS_STATUS);
        check(rd & 32'h04, 32'h04, "overflow");
        @(posedge core_clk) drain <= 1'b1;
        @(posedge core_clk) drain <= 1'b0;
        rdx(OFS_STATUS);
        check(rd & 32'hfc, 32'hec, "sticky flags");
        wr(OFS_STATUS, 32'hcc);
        rdx(OFS_STATUS);
        check(rd & 32'hfc, 32'h20, "flag clear");
        // frame timing in repeat mode is loose, count frames only
        loose = 1'b1;
        wr(OFS_DELAY, 32'h1);
        wr(OFS_COUNT, 32'h1);
        k = n_frame;
        arm(mk(SRC_INTERNAL, 1'b1, 1'b0, 1'b1));
        repeat (16) tick(1'b0);
        check(32'(n_frame - k > 2), 32'h1, "no repeats");
        wr(OFS_CTRL, 32'h0);
        check(32'(q.size()), 32'h0, "words missing");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
